// ===== dv/fdcr_core_chk.sv
/* fdcr_core_chk: concurrent checks on flag handshakes, replies and second monitor.
   assumes: bound to fdcr_core; one clock, synchronous active-high rst. */
`timescale 1ns/1ps
module fdcr_core_chk (
   // clock and reset
   input wire logic        sys_clk,
   input wire logic        rst,
   // master side
   input wire logic [15:0] monitor_select,
   input wire logic [15:0] frequency_setpoint,
   input wire logic [15:0] instruction_word,
   input wire logic [15:0] instruction_write_data,
   input wire logic        freq_volatile_cmd,
   input wire logic        freq_nonvolatile_cmd,
   input wire logic        execute_cmd,
   // drive side
   input wire logic [15:0] output_frequency,
   input wire logic [15:0] mode_selection_param,
   input wire logic [15:0] freq_volatile_store,
   input wire logic [15:0] second_monitor_value,
   input wire logic [15:0] reply_result,
   input wire logic        freq_volatile_done,
   input wire logic        execute_done
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////
   sequence exec_rise; $rose(execute_cmd); endsequence
   sequence exec_fin; $rose(execute_done); endsequence
   // frequency flags stay low so no other reply source can move the word
   sequence exec_held;
      (execute_cmd && !freq_volatile_cmd && !freq_nonvolatile_cmd)[*4];
   endsequence
   exec_done_a: assert property (exec_rise |-> ##[1:2] execute_done)
      else $error("execute done missing");
   vol_done_a: assert property ($rose(freq_volatile_cmd) |-> ##[1:2] freq_volatile_done)
      else $error("volatile done missing");
   vol_fall_a: assert property ($fell(freq_volatile_cmd) |-> ##[0:2] !freq_volatile_done)
      else $error("volatile done stuck");
   vol_store_a: assert property ($rose(freq_volatile_done) && reply_result == 16'h0000
      |-> freq_volatile_store == frequency_setpoint) else $error("volatile store wrong");
   one_shot_a: assert property (exec_held |=> $stable(reply_result))
      else $error("reply moved while flag held");
   panel_guard_a: assert property (exec_fin ##0 (instruction_word == 16'h00fb
      && instruction_write_data == 16'h0002 && mode_selection_param != 16'h0006)
      |-> reply_result != 16'h0000) else $error("panel mode taken");
   bad_code_a: assert property (exec_fin ##0 instruction_word == 16'h00f0
      |-> reply_result == 16'h0002) else $error("bad code reply wrong");
   sec_freq_a: assert property (
      (monitor_select[15:8] == 8'h00 && $stable(output_frequency))[*5]
      |-> second_monitor_value == output_frequency) else $error("second monitor wrong");
endmodule : fdcr_core_chk

bind fdcr_core fdcr_core_chk u_chk (.sys_clk, .rst, .monitor_select, .frequency_setpoint,
   .instruction_word, .instruction_write_data, .freq_volatile_cmd, .freq_nonvolatile_cmd,
   .execute_cmd, .output_frequency, .mode_selection_param, .freq_volatile_store,
   .second_monitor_value, .reply_result, .freq_volatile_done, .execute_done);

// ===== dv/fdcr_core_tb.sv
/* fdcr_core_tb: self-checking bench for the drive command register block.
   assumes: fdcr_master_mdl plays the network master; drive status comes from here. */
`timescale 1ns/1ps
module fdcr_core_tb;
   typedef struct packed {logic [15:0] rep; logic [15:0] dat;} fdcr_exp_t;
   localparam logic [15:0] dc = 'x;
   localparam logic [31:0] clr[4] = '{32'h00fc_9696, 32'h00fc_9966, 32'h00fc_9669, 32'h00fd_9696};
   localparam logic [47:0] mons[3] = '{48'h0002_5a02_0000, 48'h0602_5a02_5a06, 48'h1504_0000_0000};
   logic        sys_clk = 1'b0;
   logic        rst = 1'b1;
   logic [15:0] monitor_select, frequency_setpoint, instruction_word, instruction_write_data;
   logic [15:0] output_frequency, mode_selection_param, param_rd_data, first_monitor_value;
   logic [15:0] second_monitor_value, reply_result, instruction_read_data, operating_mode;
   logic [15:0] freq_volatile_store, freq_nonvolatile_store, monitor_value, v, w;
   logic [7:0]  monitor_code, alarm_code, alm[8];
   logic [2:0]  cmd, done_p = '0;
   wire  [2:0]  done;
   logic [15:0] param_wr_data;
   logic [6:0]  param_index;
   logic [3:0]  link_extension;
   logic [1:0]  secondary_selector;
   logic        param_in_range;
   logic        monitor_cmd, monitoring_flag, drive_running, param_reachable, alarm_event;
   logic        param_wr_stb, factory_clear_stb, all_clear_stb, user_clear_stb, drive_reset_stb;
   logic [4:0]  seen = '0;
   fdcr_exp_t   q[$];
   int          errors, n_compared;
   always #50 sys_clk = ~sys_clk;
   // monitored quantity echoes its code so a wrong selection shows
   assign monitor_value = {8'h5a, monitor_code};
   fdcr_master_mdl m (.sys_clk, .monitor_select, .frequency_setpoint, .instruction_word,
      .instruction_write_data, .monitor_cmd, .cmd, .done);
   fdcr_core DUT (.sys_clk, .rst, .monitor_select, .frequency_setpoint, .instruction_word,
      .instruction_write_data, .monitor_cmd, .freq_volatile_cmd(cmd[1]),
      .freq_nonvolatile_cmd(cmd[2]), .execute_cmd(cmd[0]), .monitor_value, .monitor_code,
      .output_frequency, .drive_running, .mode_selection_param, .param_rd_data,
      .param_reachable, .param_in_range, .alarm_event, .alarm_code, .param_wr_stb,
      .param_index, .param_wr_data, .factory_clear_stb, .all_clear_stb, .user_clear_stb,
      .drive_reset_stb, .operating_mode, .freq_volatile_store, .freq_nonvolatile_store,
      .link_extension, .secondary_selector, .first_monitor_value, .second_monitor_value,
      .reply_result, .instruction_read_data, .monitoring_flag, .freq_volatile_done(done[1]),
      .freq_nonvolatile_done(done[2]), .execute_done(done[0]));
   ////////////////////////////////////////
   task automatic cmp16(input logic [15:0] act, exp, input string what);
      n_compared++;
      if (act !== exp) begin
         errors++;
         $display("CHECK FAILED %0t %s got %h want %h", $time, what, act, exp);
      end
   endtask : cmp16
   task automatic close_out;
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : close_out
   // rep ffff stands for any non-zero reply; dat dc skips the data word
   task automatic run(input int k, input logic [15:0] a, b, rep, dat);
      bit ok;
      q.push_back('{rep, dat});
      m.send(k, a, b, ok);
      if (!ok) begin
         errors++;
         $display("CHECK FAILED %0t no completion", $time);
         close_out();
      end
   endtask : run
   task automatic check(input int i);
      fdcr_exp_t e;
      e = q.pop_front();
      if (e.rep === 16'hffff) cmp16(16'(reply_result != 0), 16'h0001, "reply");
      else cmp16(reply_result, e.rep, "reply");
      if (e.rep === 16'h0000 && e.dat !== dc) cmp16(i == 0 ? instruction_read_data :
         i == 1 ? freq_volatile_store : freq_nonvolatile_store, e.dat, "data");
   endtask : check
   always @(negedge sys_clk) begin
      done_p <= done;
      seen <= seen | {param_wr_stb, drive_reset_stb, user_clear_stb, all_clear_stb,
                      factory_clear_stb};
      for (int i = 0; i < 3; i++) begin
         if (done[i] === 1'b1 && done_p[i] !== 1'b1) begin
            if (q.size() == 0) cmp16(16'h0000, 16'h0001, "unexpected done");
            else check(i);
         end
      end
   end
   ////////////////////////////////////////
   initial begin
      {drive_running, alarm_event, alarm_code, mode_selection_param} = '0;
      {param_reachable, param_in_range} = 2'b11;
      void'($urandom(32'h719b));
      {output_frequency, param_rd_data, v, w} = {$urandom(), $urandom()};
      repeat (20) @(negedge sys_clk);
      rst = 1'b0;
      @(negedge sys_clk);
      cmp16(operating_mode, 16'h0001, "reset mode");
      // strobe held up across the burst: one new alarm per clock
      alarm_event = 1'b1;
      foreach (alm[i]) begin
         alm[i] = 8'($urandom_range(255, 1));
         alarm_code = alm[i];
         @(negedge sys_clk);
      end
      alarm_event = 1'b0;
      for (int i = 0; i < 4; i++) begin
         run(0, 16'h0074 + 16'(i), '0, '0, {alm[7-2*i], alm[6-2*i]});
      end
      run(0, 16'h00f4, 16'h9696, '0, dc);
      run(0, 16'h0074, '0, '0, '0);
      run(0, 16'h007b, '0, '0, 16'h0001);
      run(0, 16'h00fb, 16'h0002, 16'hffff, dc);
      mode_selection_param = 16'h0006;
      run(0, 16'h00fb, 16'h0002, '0, dc);
      run(0, 16'h007b, '0, '0, 16'h0002);
      run(0, 16'h00fb, 16'h0000, '0, dc);
      run(0, 16'h007b, '0, '0, 16'h0000);
      run(1, v, '0, '0, v);
      run(0, 16'h006d, '0, '0, v);
      run(2, w, '0, '0, w);
      run(0, 16'h006e, '0, '0, w);
      run(0, 16'h00ed, w, '0, dc);
      run(0, 16'h006d, '0, '0, w);
      run(0, 16'h00ee, v, '0, dc);
      run(0, 16'h006e, '0, '0, v);
      run(0, 16'h00ff, 16'h0009, '0, dc);
      run(0, 16'h007f, '0, '0, 16'h0009);
      run(0, 16'h00ff, 16'h000a, 16'h0003, dc);
      cmp16({12'h000, link_extension}, 16'h0009, "link ext");
      run(0, 16'h00ec, 16'h0002, '0, dc);
      run(0, 16'h006c, '0, '0, 16'h0002);
      run(0, 16'h00ec, 16'h0003, 16'h0003, dc);
      cmp16({14'h0000, secondary_selector}, 16'h0002, "selector");
      run(0, 16'h0010, '0, '0, param_rd_data);
      param_reachable = 1'b0;
      run(0, 16'h0010, '0, 16'h0002, dc);
      param_reachable = 1'b1;
      drive_running = 1'b1;
      run(0, 16'h0090, v, 16'h0001, dc);
      drive_running = 1'b0;
      run(0, 16'h0090, v, '0, dc);
      cmp16({9'h000, param_index}, 16'h0010, "index");
      cmp16(param_wr_data, v, "write data");
      param_in_range = 1'b0;
      run(0, 16'h0090, w, 16'h0003, dc);
      param_in_range = 1'b1;
      run(0, 16'h00f0, '0, 16'h0002, dc);
      run(0, 16'h00fc, 16'h1234, 16'h0003, dc);
      foreach (mons[i]) begin
         m.mon(mons[i][47:32], 1'b1);
         repeat (6) @(negedge sys_clk);
         cmp16(16'(monitoring_flag), 16'h0001, "monitoring");
         cmp16(first_monitor_value, mons[i][31:16], "first");
         cmp16(second_monitor_value, i == 0 ? output_frequency : mons[i][15:0], "second");
      end
      // with the command off the first word must hold, the second runs free
      m.mon(16'h0002, 1'b0);
      repeat (6) @(negedge sys_clk);
      cmp16(16'(monitoring_flag), 16'h0000, "monitoring off");
      cmp16(first_monitor_value, 16'h0000, "first held");
      cmp16(second_monitor_value, output_frequency, "second free");
      foreach (clr[i]) run(0, clr[i][31:16], clr[i][15:0], '0, dc);
      cmp16({11'h000, seen}, 16'h001f, "strobes");
      close_out();
   end
endmodule : fdcr_core_tb

// ===== dv/fdcr_master_mdl.sv
/* fdcr_master_mdl: network master loading command words and raising command flags.
   assumes: called from the bench thread; changes its outputs at the falling edge. */
`timescale 1ns/1ps
module fdcr_master_mdl (
   // clock
   input  wire logic        sys_clk,
   // words and flags, flag 0 execute, 1 volatile, 2 nonvolatile
   output logic      [15:0] monitor_select,
   output logic      [15:0] frequency_setpoint,
   output logic      [15:0] instruction_word,
   output logic      [15:0] instruction_write_data,
   output logic             monitor_cmd,
   output logic      [2:0]  cmd,
   // completion flags
   input  wire logic [2:0]  done
);
   initial begin
      {monitor_select, frequency_setpoint, instruction_word, instruction_write_data} = '0;
      monitor_cmd = 1'b0;
      cmd = 3'b000;
   end
   ////////////////////////////////////////
   task automatic send(input int k, input logic [15:0] a, b, output bit ok);
      @(negedge sys_clk);
      if (k == 0) begin
         instruction_word = a;
         instruction_write_data = b;
      end else begin
         frequency_setpoint = a;
      end
      @(negedge sys_clk);
      cmd[k] = 1'b1;
      repeat (20) if (done[k] !== 1'b1) @(negedge sys_clk);
      ok = done[k] === 1'b1;
      // a slow master keeps the flag up; the block must not act twice
      repeat (1 + $urandom_range(3)) @(negedge sys_clk);
      cmd[k] = 1'b0;
      repeat (20) if (done[k] !== 1'b0) @(negedge sys_clk);
      ok = ok && done[k] === 1'b0;
   endtask : send
   task automatic mon(input logic [15:0] sel, input logic on);
      @(negedge sys_clk);
      monitor_select = sel;
      @(negedge sys_clk);
      monitor_cmd = on;
   endtask : mon
endmodule : fdcr_master_mdl

// ===== include/fdcr_pkg.sv
/*
 fdcr_pkg: constants, types and codes shared by the fieldbus drive command register block.
 assumes: one drive-side clock at 10 MHz, synchronous active-high reset.
*/
package fdcr_pkg;

   // instruction codes
   localparam logic [15:0] INS_PAR_RD_LAST   = 16'h006c;
   localparam logic [15:0] INS_SECOND_RD     = 16'h006c;
   localparam logic [15:0] INS_FREQ_VOL_RD   = 16'h006d;
   localparam logic [15:0] INS_FREQ_NV_RD    = 16'h006e;
   localparam logic [15:0] INS_ALARM_12      = 16'h0074;
   localparam logic [15:0] INS_ALARM_78      = 16'h0077;
   localparam logic [15:0] INS_MODE_RD       = 16'h007b;
   localparam logic [15:0] INS_LINKEXT_RD    = 16'h007f;
   localparam logic [15:0] INS_PAR_WR_FIRST  = 16'h0080;
   localparam logic [15:0] INS_PAR_WR_LAST   = 16'h00ec;
   localparam logic [15:0] INS_SECOND_WR     = 16'h00ec;
   localparam logic [15:0] INS_FREQ_VOL_WR   = 16'h00ed;
   localparam logic [15:0] INS_FREQ_NV_WR    = 16'h00ee;
   localparam logic [15:0] INS_ALARM_CLR     = 16'h00f4;
   localparam logic [15:0] INS_MODE_WR       = 16'h00fb;
   localparam logic [15:0] INS_PAR_CLR       = 16'h00fc;
   localparam logic [15:0] INS_DRIVE_RST     = 16'h00fd;
   localparam logic [15:0] INS_LINKEXT_WR    = 16'h00ff;

   // write-data keys
   localparam logic [15:0] KEY_9696          = 16'h9696;
   localparam logic [15:0] KEY_ALL_CLR       = 16'h9966;
   localparam logic [15:0] KEY_USER_CLR      = 16'h9669;

   // operating modes
   localparam logic [15:0] MODE_NETWORK      = 16'h0000;
   localparam logic [15:0] MODE_EXTERNAL     = 16'h0001;
   localparam logic [15:0] MODE_PANEL        = 16'h0002;
   localparam logic [15:0] MODE_SEL_PANEL_OK = 16'h0006;

   // ranges
   localparam logic [15:0] LINKEXT_MAX       = 16'h0009;
   localparam logic [15:0] SECOND_MAX        = 16'h0002;

   // reply codes
   localparam logic [15:0] RPL_OK            = 16'h0000;
   localparam logic [15:0] RPL_WRITE_ERR     = 16'h0001;
   localparam logic [15:0] RPL_SEL_ERR       = 16'h0002;
   localparam logic [15:0] RPL_RANGE_ERR     = 16'h0003;

   // monitor codes; 04, 15 and codes above MON_LAST give a fixed zero result
   localparam logic [7:0]  MON_NONE          = 8'h00;
   localparam logic [7:0]  MON_OUT_FREQ      = 8'h01;
   localparam logic [7:0]  MON_NONE_4        = 8'h04;
   localparam logic [7:0]  MON_NONE_15       = 8'h15;
   localparam logic [7:0]  MON_LAST          = 8'h19;

   // reset values
   localparam logic [15:0] RST_WORD          = 16'h0000;
   localparam logic [15:0] RST_MODE          = 16'h0001;

   typedef enum logic [1:0] {
      FDCR_CMD_NONE,
      FDCR_CMD_FREQ_VOL,
      FDCR_CMD_FREQ_NV,
      FDCR_CMD_EXEC
   } fdcr_cmd_t;

endpackage : fdcr_pkg

// ===== verilog/fdcr_core.sv
/*
 fdcr_core: command/monitor register handshake of a drive fieldbus option, drive side.
 assumes: the link layer presents the four command words and four command flags as
 levels synchronous to sys_clk; the drive core supplies monitor quantities and parameter
 read data, and takes store/clear/reset strobes.
*/
`timescale 1ns/1ps

module fdcr_core #(
   parameter int ALARM_DEPTH = 8
) (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst,
   // command words from master
   input  wire logic [15:0] monitor_select,
   input  wire logic [15:0] frequency_setpoint,
   input  wire logic [15:0] instruction_word,
   input  wire logic [15:0] instruction_write_data,
   // command flags from master
   input  wire logic        monitor_cmd,
   input  wire logic        freq_volatile_cmd,
   input  wire logic        freq_nonvolatile_cmd,
   input  wire logic        execute_cmd,
   // drive status inputs and monitor code output
   input  wire logic [15:0] monitor_value,
   output logic      [7:0]  monitor_code,
   input  wire logic [15:0] output_frequency,
   input  wire logic        drive_running,
   input  wire logic [15:0] mode_selection_param,
   input  wire logic [15:0] param_rd_data,
   input  wire logic        param_reachable,
   input  wire logic        param_in_range,
   input  wire logic        alarm_event,
   input  wire logic [7:0]  alarm_code,
   // drive action strobes and settings
   output logic             param_wr_stb,
   output logic      [6:0]  param_index,
   output logic      [15:0] param_wr_data,
   output logic             factory_clear_stb,
   output logic             all_clear_stb,
   output logic             user_clear_stb,
   output logic             drive_reset_stb,
   output logic      [15:0] operating_mode,
   output logic      [15:0] freq_volatile_store,
   output logic      [15:0] freq_nonvolatile_store,
   output logic      [3:0]  link_extension,
   output logic      [1:0]  secondary_selector,
   // answers to master
   output logic      [15:0] first_monitor_value,
   output logic      [15:0] second_monitor_value,
   output logic      [15:0] reply_result,
   output logic      [15:0] instruction_read_data,
   output logic             monitoring_flag,
   output logic             freq_volatile_done,
   output logic             freq_nonvolatile_done,
   output logic             execute_done
);

   typedef struct packed {
      logic        mon_q, fv_q, fn_q, ex_q;
      logic [15:0] mon1, mon2, reply, rdata;
      logic        mon_flag, fv_done, fn_done, ex_done;
      logic [15:0] mode, f_vol, f_nv;
      logic [3:0]  linkext;
      logic [1:0]  second;
      logic        pwr, fclr, aclr, uclr, drst;
      logic [6:0]  pidx;
      logic [15:0] pdata;
      logic [7:0]  mcode;
      logic        mon_phase;
      logic [ALARM_DEPTH*8-1:0] alarms;
   } fdcr_state_t;

   fdcr_state_t s_q, s_d;

   function automatic logic mon_zero(input logic [7:0] c);
      mon_zero = (c == fdcr_pkg::MON_NONE_4) || (c == fdcr_pkg::MON_NONE_15) ||
                 (c > fdcr_pkg::MON_LAST);
   endfunction : mon_zero

   ///////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      logic [15:0] ins;
      logic [15:0] wd;
      logic        busy_lock;
      logic [2:0]  pair;
      ins       = instruction_word;
      wd        = instruction_write_data;
      busy_lock = drive_running || (s_q.mode != fdcr_pkg::MODE_NETWORK);
      pair      = '0;
      s_d       = s_q;
      s_d.mon_q = monitor_cmd;
      s_d.fv_q  = freq_volatile_cmd;
      s_d.fn_q  = freq_nonvolatile_cmd;
      s_d.ex_q  = execute_cmd;
      s_d.pwr   = 1'b0;
      s_d.fclr  = 1'b0;
      s_d.aclr  = 1'b0;
      s_d.uclr  = 1'b0;
      s_d.drst  = 1'b0;

      // alarm history shift, newest in the low byte
      if (alarm_event) begin
         s_d.alarms = {s_q.alarms[ALARM_DEPTH*8-9:0], alarm_code};
      end

      // monitor: one shared quantity port, low and high selections alternate each cycle
      s_d.mon_phase = ~s_q.mon_phase;
      s_d.mcode     = s_d.mon_phase ? monitor_select[15:8] : monitor_select[7:0];
      s_d.mon_flag  = monitor_cmd;
      if (monitor_cmd) begin
         if (s_q.mon_phase == 1'b0) begin
            s_d.mon1 = (s_q.mcode == fdcr_pkg::MON_NONE || mon_zero(s_q.mcode)) ?
                       fdcr_pkg::RST_WORD : monitor_value;
         end else if (monitor_select[15:8] != fdcr_pkg::MON_NONE) begin
            s_d.mon2 = mon_zero(s_q.mcode) ? fdcr_pkg::RST_WORD : monitor_value;
         end
      end
      if (monitor_select[15:8] == fdcr_pkg::MON_NONE) begin
         s_d.mon2 = output_frequency;
      end

      // frequency store commands; the master has set the word beforehand
      if (freq_volatile_cmd && !s_q.fv_q) begin
         s_d.f_vol   = frequency_setpoint;
         s_d.fv_done = 1'b1;
         s_d.reply   = fdcr_pkg::RPL_OK;
      end else if (!freq_volatile_cmd) begin
         s_d.fv_done = 1'b0;
      end
      if (freq_nonvolatile_cmd && !s_q.fn_q) begin
         s_d.f_nv    = frequency_setpoint;
         s_d.fn_done = 1'b1;
         s_d.reply   = fdcr_pkg::RPL_OK;
      end else if (!freq_nonvolatile_cmd) begin
         s_d.fn_done = 1'b0;
      end

      // instruction execution; word and data are stable before the flag
      if (!execute_cmd) begin
         s_d.ex_done = 1'b0;
      end
      if (execute_cmd && !s_q.ex_q) begin
         s_d.ex_done = 1'b1;
         s_d.reply   = fdcr_pkg::RPL_OK;
         s_d.rdata   = fdcr_pkg::RST_WORD;
         if (ins == fdcr_pkg::INS_MODE_RD) begin
            s_d.rdata = s_q.mode;
         end else if (ins == fdcr_pkg::INS_MODE_WR) begin
            if (wd == fdcr_pkg::MODE_NETWORK || wd == fdcr_pkg::MODE_EXTERNAL ||
                (wd == fdcr_pkg::MODE_PANEL &&
                 mode_selection_param == fdcr_pkg::MODE_SEL_PANEL_OK)) begin
               s_d.mode = wd;
            end else begin
               s_d.reply = fdcr_pkg::RPL_RANGE_ERR;
            end
         end else if (ins >= fdcr_pkg::INS_ALARM_12 && ins <= fdcr_pkg::INS_ALARM_78) begin
            pair      = 3'(ins - fdcr_pkg::INS_ALARM_12);
            // entries one-two, three-four... in the high and low byte
            s_d.rdata = {s_q.alarms[pair*16 +: 8], s_q.alarms[pair*16+8 +: 8]};
         end else if (ins == fdcr_pkg::INS_FREQ_VOL_RD) begin
            s_d.rdata = s_q.f_vol;
         end else if (ins == fdcr_pkg::INS_FREQ_NV_RD) begin
            s_d.rdata = s_q.f_nv;
         end else if (ins == fdcr_pkg::INS_FREQ_VOL_WR) begin
            s_d.f_vol = wd;
         end else if (ins == fdcr_pkg::INS_FREQ_NV_WR) begin
            s_d.f_nv  = wd;
         end else if (ins == fdcr_pkg::INS_SECOND_RD) begin
            s_d.rdata = {14'h0000, s_q.second};
         end else if (ins == fdcr_pkg::INS_SECOND_WR) begin
            if (wd > fdcr_pkg::SECOND_MAX) begin
               s_d.reply = fdcr_pkg::RPL_RANGE_ERR;
            end else begin
               s_d.second = wd[1:0];
            end
         end else if (ins == fdcr_pkg::INS_LINKEXT_RD) begin
            s_d.rdata = {12'h000, s_q.linkext};
         end else if (ins == fdcr_pkg::INS_LINKEXT_WR) begin
            if (wd > fdcr_pkg::LINKEXT_MAX) begin
               s_d.reply = fdcr_pkg::RPL_RANGE_ERR;
            end else begin
               s_d.linkext = wd[3:0];
            end
         end else if (ins < fdcr_pkg::INS_PAR_RD_LAST) begin
            s_d.pidx = ins[6:0];
            if (!param_reachable) begin
               s_d.reply = fdcr_pkg::RPL_SEL_ERR;
            end else begin
               s_d.rdata = param_rd_data;
            end
         end else if (ins >= fdcr_pkg::INS_PAR_WR_FIRST &&
                      ins < fdcr_pkg::INS_PAR_WR_LAST) begin
            s_d.pidx  = ins[6:0];
            s_d.pdata = wd;
            if (!param_reachable) begin
               s_d.reply = fdcr_pkg::RPL_SEL_ERR;
            end else if (busy_lock) begin
               s_d.reply = fdcr_pkg::RPL_WRITE_ERR;
            end else if (!param_in_range) begin
               s_d.reply = fdcr_pkg::RPL_RANGE_ERR;
            end else begin
               s_d.pwr = 1'b1;
            end
         end else if (ins == fdcr_pkg::INS_ALARM_CLR && wd == fdcr_pkg::KEY_9696) begin
            // an alarm arriving in the clear cycle survives as the newest entry
            s_d.alarms = alarm_event ? (ALARM_DEPTH*8)'(alarm_code) : '0;
         end else if (ins == fdcr_pkg::INS_PAR_CLR && wd == fdcr_pkg::KEY_9696) begin
            s_d.fclr = 1'b1;
         end else if (ins == fdcr_pkg::INS_PAR_CLR && wd == fdcr_pkg::KEY_ALL_CLR) begin
            s_d.aclr = 1'b1;
         end else if (ins == fdcr_pkg::INS_PAR_CLR && wd == fdcr_pkg::KEY_USER_CLR) begin
            s_d.uclr = 1'b1;
         end else if (ins == fdcr_pkg::INS_DRIVE_RST && wd == fdcr_pkg::KEY_9696) begin
            s_d.drst = 1'b1;
         end else if (ins == fdcr_pkg::INS_ALARM_CLR || ins == fdcr_pkg::INS_PAR_CLR ||
                      ins == fdcr_pkg::INS_DRIVE_RST) begin
            s_d.reply = fdcr_pkg::RPL_RANGE_ERR;
         end else begin
            s_d.reply = fdcr_pkg::RPL_SEL_ERR;
         end
      end
   end

   ///////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         s_q      <= '0;
         s_q.mode <= fdcr_pkg::RST_MODE;
      end else begin
         s_q <= s_d;
      end
   end

   ///////////////////////////////////////////////////////////////////////////////////
   assign monitor_code           = s_q.mcode;
   assign first_monitor_value    = s_q.mon1;
   assign second_monitor_value   = s_q.mon2;
   assign reply_result           = s_q.reply;
   assign instruction_read_data  = s_q.rdata;
   assign monitoring_flag        = s_q.mon_flag;
   assign freq_volatile_done     = s_q.fv_done;
   assign freq_nonvolatile_done  = s_q.fn_done;
   assign execute_done           = s_q.ex_done;
   assign operating_mode         = s_q.mode;
   assign freq_volatile_store    = s_q.f_vol;
   assign freq_nonvolatile_store = s_q.f_nv;
   assign link_extension         = s_q.linkext;
   assign secondary_selector     = s_q.second;
   assign param_wr_stb           = s_q.pwr;
   assign param_index            = s_q.pidx;
   assign param_wr_data          = s_q.pdata;
   assign factory_clear_stb      = s_q.fclr;
   assign all_clear_stb          = s_q.aclr;
   assign user_clear_stb         = s_q.uclr;
   assign drive_reset_stb        = s_q.drst;

endmodule : fdcr_core
